// ===== logic/svl_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module svl_receiver #(
	parameter int LOCK_TC_CYC = svl_pkg::LOCK_TC_CYC,
	parameter int INT_W = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic serial_data_in,
	input wire logic bypass_n,
	input wire logic serial_out_enable_n,
	output logic retimed_serial_out,
	output logic retimed_serial_oe,
	output logic [svl_pkg::WORD_W-1:0] parallel_word_out,
	output logic parallel_word_clk,
	output logic loop_locked,
	output logic [7:0] jitter_indicator_out,
	output logic [15:0] lock_filter_node,
	output logic [INT_W-1:0] integrator_node,
	output logic [15:0] oscillator_control_out
);

	localparam int FILT_SHIFT = $clog2(LOCK_TC_CYC) - 1;
	localparam int ACC_W = 16 + FILT_SHIFT;
	localparam logic [INT_W-1:0] INT_MAX = '1;
	localparam logic [INT_W-1:0] INT_MID = INT_W'(1 << (INT_W - 1));
	localparam int IDLE_W = $clog2(svl_pkg::IDLE_DRIFT_CYC + 1);

	logic data_s1_q, data_s2_q, data_prev_q;
	logic byp_s1_q, byp_s2_q, en_s1_q, en_s2_q;
	logic [15:0] phase_q, step, qphase;
	logic [16:0] phase_sum;
	logic bit_en, transition, inphase_clk, quad_clk;
	logic quad_sample_q, pd_late_q;
	logic [INT_W-1:0] integ_q;
	logic int_sat, int_sat_prev_q, sweep_up_q;
	logic [$clog2(svl_pkg::SWEEP_DIV)-1:0] sweep_cnt_q;
	logic sweep_tick;
	logic idle;
	logic [IDLE_W-1:0] idle_cnt_q;
	logic [ACC_W-1:0] acc_q;
	logic phase_lock_q, retimed_bit_q;
	logic [2:0] ctrl_q;
	logic [15:0] prop;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [svl_pkg::WORD_W-1:0] word;
	logic word_clk;
	svl_pkg::svl_status_type status;

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_s1_q <= 1'b0;
			data_s2_q <= 1'b0;
			data_prev_q <= 1'b0;
			byp_s1_q <= 1'b1;
			byp_s2_q <= 1'b1;
			en_s1_q <= 1'b1;
			en_s2_q <= 1'b1;
		end else begin
			data_s1_q <= serial_data_in;
			data_s2_q <= data_s1_q;
			data_prev_q <= data_s2_q;
			byp_s1_q <= bypass_n;
			byp_s2_q <= byp_s1_q;
			en_s1_q <= serial_out_enable_n;
			en_s2_q <= en_s1_q;
		end
	end

	// Recovered clock phase; in-phase clock falls at half turn, quadrature lags a quarter UI.
	assign transition = data_s2_q ^ data_prev_q;
	assign inphase_clk = ~phase_q[15];
	assign qphase = phase_q - svl_pkg::QUAD_PHASE;
	assign quad_clk = ~qphase[15];
	assign prop = svl_pkg::PROP_STEP >> ctrl_q[svl_pkg::CTRL_BW_LSB +: 2];
	assign step = 16'(svl_pkg::NOM_STEP - 16'(INT_MID) + 16'(integ_q)) + (pd_late_q ? prop : -prop);
	assign phase_sum = {1'b0, phase_q} + {1'b0, step};
	assign bit_en = phase_sum[16];

	// Oscillator phase accumulator; carry out is the in-phase rising edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_sum[15:0];
		end
	end

	// Bang-bang detector: a transition while the in-phase clock is still high means the clock lags.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			quad_sample_q <= 1'b0;
			pd_late_q <= 1'b0;
		end else if (transition) begin
			quad_sample_q <= quad_clk;
			pd_late_q <= inphase_clk;
		end
	end

	// Retimed bit is taken at the in-phase rising edge.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retimed_bit_q <= 1'b0;
		end else if (bit_en) begin
			retimed_bit_q <= data_s2_q;
		end
	end

	// Sweep rate divider.
	assign sweep_tick = (sweep_cnt_q == ($clog2(svl_pkg::SWEEP_DIV))'(svl_pkg::SWEEP_DIV - 1));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sweep_cnt_q <= '0;
		end else begin
			sweep_cnt_q <= sweep_tick ? '0 : sweep_cnt_q + 1'b1;
		end
	end

	// Cycles since the last data edge; a long silence leaves the detector output parked.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_cnt_q <= '0;
		end else if (transition) begin
			idle_cnt_q <= '0;
		end else if (!idle) begin
			idle_cnt_q <= idle_cnt_q + 1'b1;
		end
	end

	// The limit lies well beyond the longest run of equal bits, so a locked loop never sees it.
	assign idle = (idle_cnt_q == IDLE_W'(svl_pkg::IDLE_DRIFT_CYC));

	// Frequency integrator: detector steps plus sweep injection, clamped at both ends.
	// With no data the parked detector charges it every cycle except enabled sweep ticks while unlocked, until it reaches a rail.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			integ_q <= INT_MID;
		end else begin
			if (sweep_tick && !phase_lock_q && ctrl_q[svl_pkg::CTRL_SWEEP_EN_BIT]) begin
				if (sweep_up_q && integ_q != INT_MAX) begin
					integ_q <= integ_q + 1'b1;
				end else if (!sweep_up_q && integ_q != '0) begin
					integ_q <= integ_q - 1'b1;
				end
			end else if (transition || idle) begin
				if (pd_late_q && integ_q != INT_MAX) begin
					integ_q <= integ_q + 1'b1;
				end else if (!pd_late_q && integ_q != '0) begin
					integ_q <= integ_q - 1'b1;
				end
			end
		end
	end

	// Saturation at either rail stands for absent input data.
	assign int_sat = (integ_q == INT_MAX) || (integ_q == '0);

	// Sweep direction turns round on each arrival at a rail.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_sat_prev_q <= 1'b0;
			sweep_up_q <= 1'b1;
		end else begin
			int_sat_prev_q <= int_sat;
			if (int_sat && !int_sat_prev_q) begin
				sweep_up_q <= (integ_q == '0);
			end
		end
	end

	// Leaky accumulator: a window of about 2^FILT_SHIFT cycles, near one video line.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_q - (acc_q >> FILT_SHIFT) + (quad_sample_q ? ACC_W'(16'hFFFF) : '0);
		end
	end

	// Phase lock above the 0.66 mark; unlocked input settles near half scale.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_lock_q <= 1'b0;
		end else begin
			phase_lock_q <= acc_q[ACC_W-1 -: 16] > svl_pkg::LOCK_THRESH;
		end
	end

	// Loop lock needs data and phase lock; bypass does not enter into it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loop_locked <= 1'b0;
		end else begin
			loop_locked <= phase_lock_q && !int_sat;
		end
	end

	// Filter node and buffered jitter level; low values mean many outside-window edges.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_filter_node <= '0;
			jitter_indicator_out <= '0;
		end else begin
			lock_filter_node <= acc_q[ACC_W-1 -: 16];
			jitter_indicator_out <= acc_q[ACC_W-1 -: 8];
		end
	end

	// Serial output: raw data in bypass with mute ignored, else retimed bit muted while unlocked.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retimed_serial_out <= 1'b0;
			retimed_serial_oe <= 1'b0;
		end else begin
			if (!byp_s2_q) begin
				retimed_serial_out <= data_s2_q;
			end else begin
				retimed_serial_out <= retimed_bit_q & loop_locked;
			end
			retimed_serial_oe <= !en_s2_q;
		end
	end

	// Deserialiser runs from the free-running recovered bit edge.
	svl_deser #(
		.WORD_W(svl_pkg::WORD_W)
	) u_deser (
		.hclk(hclk),
		.hresetn(hresetn),
		.bit_en(bit_en),
		.bit_in(data_s2_q),
		.word_q(word),
		.word_clk_q(word_clk)
	);

	// Parallel outputs and loop monitor outputs are registered here.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			parallel_word_out <= '0;
			parallel_word_clk <= 1'b0;
			integrator_node <= '0;
			oscillator_control_out <= '0;
		end else begin
			parallel_word_out <= word;
			parallel_word_clk <= word_clk;
			integrator_node <= integ_q;
			oscillator_control_out <= step;
		end
	end

	assign status = '{bypass_active: !byp_s2_q, sweep_up: sweep_up_q, no_data: int_sat,
		phase_lock: phase_lock_q, loop_lock: loop_locked};

	// Bus write address phase is held for the following data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (hready) begin
			wr_pend_q <= hsel && htrans[1] && hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Control register written in the data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= svl_pkg::CTRL_RESET;
		end else if (wr_pend_q && wr_addr_q == svl_pkg::CTRL_OFS) begin
			ctrl_q <= hwdata[2:0];
		end
	end

	// Read data is captured at the address phase, so the data phase has no wait state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			if (haddr[7:0] == svl_pkg::CTRL_OFS && haddr[31:8] == '0) begin
				hrdata <= {29'h0, ctrl_q};
			end else if (haddr[7:0] == svl_pkg::STATUS_OFS && haddr[31:8] == '0) begin
				hrdata <= {27'h0, status};
			end else if (haddr[7:0] == svl_pkg::FILTER_OFS && haddr[31:8] == '0) begin
				hrdata <= {16'h0, lock_filter_node};
			end else if (haddr[7:0] == svl_pkg::WORD_OFS && haddr[31:8] == '0) begin
				hrdata <= {12'h0, parallel_word_out};
			end else if (haddr[7:0] == svl_pkg::INTEG_OFS && haddr[31:8] == '0) begin
				hrdata <= 32'(integ_q);
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// Always ready, always OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize, hwdata[31:3], haddr[31:8], svl_pkg::QUAD_TOL_MUI[0]};

endmodule
`default_nettype wire

// ===== logic/svl_pkg.sv
// Operation
// - Quadrature clock is in-phase clock delayed quarter UI.
// - Latch quadrature level on each data transition.
// - Phase lock when filtered average exceeds 0.66.
// - Average samples over about 67 us.
// - Filter outside-window transitions into jitter indicator.
// - Integrator saturation at either end means no data.
// - Loop lock only with data and phase lock.
// - Sweep integrator for acquisition; stop on phase lock.
// - Reverse sweep direction on each saturation.
// - Bypass input low routes raw data around retimer.
// - Mute has no effect while bypassed.
// - Loop still locks and reports while bypassed.
// - Active-low enable gates the serial output driver.
// - Deserialise retimed bits into 20-bit words.
// - Words carry no alignment and no descrambling.
// - Word clock runs at one twentieth bit rate.
// - Word clock keeps running when lock is lost.
// - Align transitions to falling edge, sample on rising.
package svl_pkg;

	// Register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] FILTER_OFS = 8'h08;
	localparam logic [7:0] WORD_OFS = 8'h0C;
	localparam logic [7:0] INTEG_OFS = 8'h10;

	// Control field positions and reset value.
	localparam int CTRL_BW_LSB = 0;
	localparam int CTRL_SWEEP_EN_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h4;

	// Timing of the lock filter.
	localparam int CLK_PERIOD_PS = 4000;
	localparam int LOCK_TC_NS = 67000;
	localparam int LOCK_TC_CYC = (LOCK_TC_NS * 1000) / CLK_PERIOD_PS;

	// Recovered clock model: one UI is a full turn of a 16-bit phase.
	localparam int UI_PS = 664;
	localparam int QUAD_DELAY_PS = 166;
	localparam int QUAD_TOL_MUI = 50;
	localparam logic [15:0] QUAD_PHASE = 16'((QUAD_DELAY_PS * 65536) / UI_PS);
	localparam logic [15:0] NOM_STEP = 16'h2000;
	localparam logic [15:0] PROP_STEP = 16'h0400;
	localparam int SWEEP_DIV = 16;

	// Silence on the line, in cycles, after which the integrator drifts to a rail.
	localparam int IDLE_DRIFT_CYC = 256;

	// Lock threshold 0.66 of full scale.
	localparam logic [15:0] LOCK_THRESH = 16'((66 * 65536) / 100);

	// Serial to parallel word width.
	localparam int WORD_W = 20;

	// Status word layout.
	typedef struct packed {
		logic bypass_active;
		logic sweep_up;
		logic no_data;
		logic phase_lock;
		logic loop_lock;
	} svl_status_type;

endpackage

// ===== logic/svl_deser.sv
`timescale 1ns/1ps
`default_nettype none
module svl_deser #(
	parameter int WORD_W = svl_pkg::WORD_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic bit_en,
	input wire logic bit_in,
	output logic [WORD_W-1:0] word_q,
	output logic word_clk_q
);

	logic [WORD_W-1:0] shift_q;
	logic [$clog2(WORD_W)-1:0] cnt_q;

	// Bit counter wraps every word, whether or not the loop is locked.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (bit_en) begin
			if (cnt_q == ($clog2(WORD_W))'(WORD_W - 1)) begin
				cnt_q <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// First bit ends up in the top bit; no framing search, no descrambler.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= '0;
		end else if (bit_en) begin
			shift_q <= {shift_q[WORD_W-2:0], bit_in};
		end
	end

	// Whole word updates once per word period, with the last bit folded in.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_q <= '0;
		end else if (bit_en && cnt_q == ($clog2(WORD_W))'(WORD_W - 1)) begin
			word_q <= {shift_q[WORD_W-2:0], bit_in};
		end
	end

	// Word clock: high for the first half of the twenty bits.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_clk_q <= 1'b0;
		end else if (bit_en) begin
			word_clk_q <= (cnt_q < ($clog2(WORD_W))'(WORD_W / 2));
		end
	end

endmodule
`default_nettype wire

// ===== verif/svl_receiver_props.sv
`timescale 1ns/1ps
`default_nettype none
module svl_receiver_props #(
	parameter int LOCK_TC_CYC = 64,
	parameter int INT_W = 12
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic serial_data_in,
	input wire logic bypass_n,
	input wire logic serial_out_enable_n,
	input wire logic retimed_serial_out,
	input wire logic retimed_serial_oe,
	input wire logic parallel_word_clk,
	input wire logic loop_locked,
	input wire logic [7:0] jitter_indicator_out,
	input wire logic [15:0] lock_filter_node,
	input wire logic [INT_W-1:0] integrator_node
);
	logic [2:0] up_q;

	// Counts the first cycles after reset so the input synchronisers have settled.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_oe_off;
		(up_q == 3'h7 && serial_out_enable_n)[*4] |-> !retimed_serial_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("driver on while disabled");
	property p_oe_on;
		(up_q == 3'h7 && !serial_out_enable_n)[*4] |-> retimed_serial_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("driver off while enabled");
	property p_bypass;
		(up_q == 3'h7 && !bypass_n && $stable(serial_data_in))[*6] |-> retimed_serial_out == serial_data_in;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass output differs from input");
	property p_mute;
		(up_q == 3'h7 && bypass_n && !loop_locked)[*5] |-> !retimed_serial_out;
	endproperty
	a_mute: assert property (p_mute) else $error("output not muted while unlocked");
	property p_rail_lo;
		(integrator_node == '0) |-> !loop_locked;
	endproperty
	a_rail_lo: assert property (p_rail_lo) else $error("locked at low rail");
	property p_rail_hi;
		(&integrator_node) |-> !loop_locked;
	endproperty
	a_rail_hi: assert property (p_rail_hi) else $error("locked at high rail");
	property p_word_clk;
		$changed(parallel_word_clk) |=> ##[0:999] $changed(parallel_word_clk);
	endproperty
	a_word_clk: assert property (p_word_clk) else $error("word clock stopped");
	property p_jitter;
		jitter_indicator_out == lock_filter_node[15:8];
	endproperty
	a_jitter: assert property (p_jitter) else $error("jitter indicator off filter");
	property p_lock;
		$rose(loop_locked) |-> lock_filter_node > 16'h8000;
	endproperty
	a_lock: assert property (p_lock) else $error("lock with low filter");
endmodule

bind svl_receiver svl_receiver_props #(.LOCK_TC_CYC(LOCK_TC_CYC), .INT_W(INT_W)) i_props (
	.hclk(hclk), .hresetn(hresetn), .serial_data_in(serial_data_in), .bypass_n(bypass_n),
	.serial_out_enable_n(serial_out_enable_n), .retimed_serial_out(retimed_serial_out),
	.retimed_serial_oe(retimed_serial_oe), .parallel_word_clk(parallel_word_clk),
	.loop_locked(loop_locked), .jitter_indicator_out(jitter_indicator_out),
	.lock_filter_node(lock_filter_node), .integrator_node(integrator_node));
`default_nettype wire

// ===== verif/svl_src.sv
`timescale 1ns/1ps
`default_nettype none
module svl_src #(
	parameter int BIT_CYC = 8,
	parameter logic [19:0] PAT = 20'hB3C1E
) (
	input wire logic clk,
	input wire logic run,
	output logic data
);
	logic [19:0] pat_q;
	int cnt;

	initial begin
		data = 1'b0;
		pat_q = PAT;
		cnt = 0;
	end

	// Sends the pattern first bit first; with no signal the line shows no transitions.
	always @(posedge clk) begin
		if (run) begin
			cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
			if (cnt == BIT_CYC - 1) begin
				data <= pat_q[19];
				pat_q <= {pat_q[18:0], pat_q[19]};
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [19:0] PAT = 20'hB3C1E;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0, bypass_n = 1'b1, oe_n = 1'b1;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, sdi, rso, rsoe, pclk, locked;
	logic [19:0] word;
	logic [7:0] jit;
	logic [15:0] filt, osc;
	logic [11:0] integ;
	int failures = 0, checks = 0, cyc = 0, t0;

	always #2 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;

	svl_src #(.BIT_CYC(8), .PAT(PAT)) i_src (.clk(hclk), .run(run), .data(sdi));
	svl_receiver #(.LOCK_TC_CYC(64)) i_svl_receiver (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serial_data_in(sdi), .bypass_n(bypass_n),
		.serial_out_enable_n(oe_n), .retimed_serial_out(rso), .retimed_serial_oe(rsoe),
		.parallel_word_out(word), .parallel_word_clk(pclk), .loop_locked(locked),
		.jitter_indicator_out(jit), .lock_filter_node(filt), .integrator_node(integ),
		.oscillator_control_out(osc));

	// Compares a value seen with the value expected and counts both outcomes.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// Waits a bounded time for loop lock to reach the wanted level.
	task automatic wait_lock(input logic want);
		int n;
		n = 0;
		while (locked !== want && n < 20000) begin
			@(posedge hclk);
			#1;
			n++;
		end
	endtask

	// True when the word is some rotation of the sent pattern, first bit at the top.
	function automatic logic is_rot(input logic [19:0] w);
		logic [39:0] r;
		for (int i = 0; i < 20; i++) begin
			r = {PAT, PAT} << i;
			if (r[39:20] === w) return 1'b1;
		end
		return 1'b0;
	endfunction

	task automatic give_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Cuts a hang short after a span well beyond the longest expected test.
	initial begin
		repeat (90000) @(posedge hclk);
		failures++;
		give_verdict();
	end

	// Main sequence of tests.
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, {24'h0, svl_pkg::CTRL_OFS}, 32'h0);
		chk("ctrl reset", rd, {29'h0, svl_pkg::CTRL_RESET});
		bus(1'b1, {24'h0, svl_pkg::CTRL_OFS}, 32'h6);
		bus(1'b0, {24'h0, svl_pkg::CTRL_OFS}, 32'h0);
		chk("ctrl", rd, 32'h6);
		bus(1'b0, 32'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		$display("test registers done");
		run <= 1'b1;
		wait_lock(1'b1);
		chk("locked", {31'h0, locked}, 32'h1);
		chk("filter high", {31'h0, filt > svl_pkg::LOCK_THRESH}, 32'h1);
		bus(1'b0, {24'h0, svl_pkg::STATUS_OFS}, 32'h0);
		chk("status lock", rd & 32'h7, 32'h3);
		bus(1'b0, {24'h0, svl_pkg::FILTER_OFS}, 32'h0);
		chk("filter reg", {31'h0, rd > {16'h0, svl_pkg::LOCK_THRESH}}, 32'h1);
		chk("osc near nominal", {31'h0, (osc >= svl_pkg::NOM_STEP - svl_pkg::PROP_STEP)
			&& (osc <= svl_pkg::NOM_STEP + svl_pkg::PROP_STEP)}, 32'h1);
		@(posedge pclk);
		t0 = cyc;
		repeat (8) @(posedge pclk);
		// The recovered bit edge wanders by a few cycles, so the period is averaged over eight words.
		chk("pclk period", (cyc - t0 + 4) / 8, 32'd160);
		@(negedge pclk);
		chk("word order", {31'h0, is_rot(word)}, 32'h1);
		bus(1'b0, {24'h0, svl_pkg::WORD_OFS}, 32'h0);
		chk("word reg", {31'h0, rd[31:20] == 12'h0 && is_rot(rd[19:0])}, 32'h1);
		$display("test lock done");
		bypass_n <= 1'b0;
		oe_n <= 1'b0;
		repeat (40) @(posedge hclk);
		#1;
		chk("bypass lock", {31'h0, locked}, 32'h1);
		chk("oe on", {31'h0, rsoe}, 32'h1);
		bus(1'b0, {24'h0, svl_pkg::STATUS_OFS}, 32'h0);
		chk("status bypass", rd & 32'h11, 32'h11);
		bypass_n <= 1'b1;
		oe_n <= 1'b1;
		$display("test bypass done");
		run <= 1'b0;
		wait_lock(1'b0);
		chk("unlocked", {31'h0, locked}, 32'h0);
		bus(1'b0, {24'h0, svl_pkg::STATUS_OFS}, 32'h0);
		chk("status no data", rd & 32'h5, 32'h4);
		bus(1'b0, {24'h0, svl_pkg::INTEG_OFS}, 32'h0);
		chk("integ rail", {31'h0, rd == 32'h0 || rd == 32'hFFF}, 32'h1);
		t0 = cyc;
		@(posedge pclk);
		chk("pclk free", {31'h0, cyc - t0 < 400}, 32'h1);
		bypass_n <= 1'b0;
		repeat (8) @(posedge hclk);
		#1;
		chk("still unlocked", {31'h0, locked}, 32'h0);
		chk("bypass unmuted", {31'h0, rso}, {31'h0, sdi});
		$display("test no data done");
		give_verdict();
	end
endmodule
`default_nettype wire
